// [hw/acs_regs.svh]
// Purpose: Offsets, fields, reset values and timing for the active copies
// Assumes: Core clock of 250 MHz
// Notes: Included by the package; the design uses its macros without including it
`ifndef ACS_REGS_SVH
`define ACS_REGS_SVH
`define ACS_OFS_CTRL_PEND 8'h01
`define ACS_OFS_RANGE_PEND 8'h1d
`define ACS_OFS_ACTIVE_CONTROL_COPY 8'h21
`define ACS_OFS_RANGE_ACT 8'h22
`define ACS_CTRL_RESET 16'h0700
`define ACS_RANGE_RESET 16'h0000
`define ACS_MODE_MSB 15
`define ACS_MODE_LSB 12
`define ACS_PIN2_MSB 11
`define ACS_PIN2_LSB 10
`define ACS_PIN1_MSB 9
`define ACS_PIN1_LSB 8
`define ACS_OFF_MSB 7
`define ACS_OFF_LSB 4
`define ACS_SKIP_BIT 1
`define ACS_CTRL_IMPL_MASK 16'hfff0
`define ACS_CTRL_STORE_MASK 16'hfff2
`define ACS_PIN_ALERT 2'h0
`define ACS_PIN_GPI 2'h1
`define ACS_PIN_GPO 2'h2
`define ACS_PIN_RATE 2'h3
`define ACS_SETTLE_US 1000
`define ACS_CLK_MHZ 250
`define ACS_SETTLE_CYC (`ACS_SETTLE_US * `ACS_CLK_MHZ)
`endif

// [hw/acs_pkg.sv]
// Purpose: Types for the active configuration copies
// Assumes: Header of constants alongside
// Notes: Mode codes and bus structs
`include "acs_regs.svh"
package acs_pkg;
  typedef enum logic [3:0]
  {
    ACS_ADAPT_1024 = 4'h0, ACS_ADAPT_256 = 4'h1,
    ACS_ADAPT_64 = 4'h2, ACS_ADAPT_8 = 4'h3,
    ACS_CONT_1024 = 4'h4, ACS_CONT_256 = 4'h5,
    ACS_CONT_64 = 4'h6, ACS_CONT_8 = 4'h7,
    ACS_SINGLE = 4'h8, ACS_SINGLE_8X = 4'h9,
    ACS_FAST = 4'ha, ACS_BURST = 4'hb,
    ACS_SLEEP = 4'hf
  } acs_mode_e;
  typedef enum logic [2:0]
  {
    ACS_IDLE = 3'b001,
    ACS_WAIT_CYCLE = 3'b010,
    ACS_SETTLE = 3'b100
  } acs_state_e;
  typedef struct packed
  {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [15:0] wdata;
  } acs_req_s;
  typedef struct packed
  {
    logic [3:0] rate_class;
    logic adaptive;
    logic continuous;
    logic single;
    logic avg8;
    logic fast;
    logic burst;
    logic sleep;
    logic reserved;
  } acs_mode_s;
endpackage

// [hw/acs_active_copy.sv]
// Purpose: Pending and active control/range copies with refresh activation
// Assumes: Register port decoded upstream into acs_req_s; pins asynchronous
// Notes: Read data returns one cycle after rd
`timescale 1ns/1ps
module acs_active_copy
  import acs_pkg::*;
#(
  parameter int CHANNELS = 4,
  parameter int SETTLE_CYC = `ACS_SETTLE_CYC
)
(
  input wire logic clk,
  input wire logic resetn,
  input wire acs_req_s req,
  input wire logic refresh,
  input wire logic pin_refresh,
  input wire logic cycle_done,
  input wire logic [1:0] pin_in,
  input wire logic [1:0] gpo_level,
  output logic [15:0] rdata,
  output logic rvalid,
  output logic copies_valid,
  output acs_mode_s active_mode,
  output logic force_8sps,
  output logic [1:0] gpi_level,
  output logic [1:0] pin_out,
  output logic [1:0] pin_oe,
  output logic [3:0] chan_active,
  output logic [2:0] chan_count,
  output logic ptr_skip_enable
);
  localparam logic [3:0] OFF_DEFAULT = (CHANNELS >= 4) ? 4'h0 :
    (CHANNELS == 3) ? 4'h1 : (CHANNELS == 2) ? 4'h3 : 4'h7;
  localparam logic [15:0] CTRL_DEFAULT =
    `ACS_CTRL_RESET | {8'h00, OFF_DEFAULT, 4'h0};
  localparam logic [19:0] SETTLE_LAST = 20'(SETTLE_CYC - 1);

  logic [15:0] ctrl_pend_q;
  logic [15:0] range_pend_q;
  logic [15:0] active_control_copy_q;
  logic [15:0] range_act_q;
  logic [15:0] ctrl_stage_q;
  acs_state_e state_q;
  logic [19:0] settle_q;
  logic [1:0] pin_m_q;
  logic [1:0] pin_s_q;
  logic rate_change;
  logic [1:0] fn [2];

  ////////////////////////////////////////////////////////////////////////
  // Pending registers
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      ctrl_pend_q <= CTRL_DEFAULT;
      range_pend_q <= `ACS_RANGE_RESET;
    end
    else if (req.wr)
    begin
      if (req.addr == `ACS_OFS_CTRL_PEND)
        ctrl_pend_q <= req.wdata & `ACS_CTRL_STORE_MASK;
      if (req.addr == `ACS_OFS_RANGE_PEND)
        range_pend_q <= req.wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Activation sequence
  assign rate_change = ctrl_pend_q[`ACS_MODE_MSB:`ACS_MODE_LSB] !=
    active_control_copy_q[`ACS_MODE_MSB:`ACS_MODE_LSB];

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_q <= ACS_IDLE;
      active_control_copy_q <= CTRL_DEFAULT;
      range_act_q <= `ACS_RANGE_RESET;
      ctrl_stage_q <= CTRL_DEFAULT;
      settle_q <= 20'h00000;
      copies_valid <= 1'b0;
    end
    else if (refresh)
    begin
      // Pin-triggered refreshes never reach here
      copies_valid <= 1'b0;
      settle_q <= 20'h00000;
      range_act_q <= range_pend_q;
      if (rate_change)
      begin
        ctrl_stage_q <= ctrl_pend_q;
        state_q <= ACS_WAIT_CYCLE;
      end
      else
      begin
        active_control_copy_q <= ctrl_pend_q;
        state_q <= ACS_SETTLE;
      end
    end
    else
    begin
      case (state_q)
        ACS_IDLE:
          state_q <= ACS_IDLE;
        ACS_WAIT_CYCLE:
          if (cycle_done)
          begin
            active_control_copy_q <= ctrl_stage_q;
            state_q <= ACS_SETTLE;
          end
        ACS_SETTLE:
          if (settle_q == SETTLE_LAST)
          begin
            copies_valid <= 1'b1;
            state_q <= ACS_IDLE;
          end
          else
            settle_q <= settle_q + 20'h00001;
        default:
          state_q <= ACS_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Register read port
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rdata <= 16'h0000;
      rvalid <= 1'b0;
    end
    else
    begin
      rvalid <= req.rd;
      case (req.addr)
        `ACS_OFS_CTRL_PEND: rdata <= ctrl_pend_q & `ACS_CTRL_IMPL_MASK;
        `ACS_OFS_RANGE_PEND: rdata <= range_pend_q;
        `ACS_OFS_ACTIVE_CONTROL_COPY: rdata <= active_control_copy_q & `ACS_CTRL_IMPL_MASK;
        `ACS_OFS_RANGE_ACT: rdata <= range_act_q;
        default: rdata <= 16'h0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Mode decode
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      active_mode <= '0;
    else
    begin
      active_mode <= '0;
      case (acs_mode_e'(active_control_copy_q[`ACS_MODE_MSB:`ACS_MODE_LSB]))
        ACS_ADAPT_1024:
        begin
          active_mode.adaptive <= 1'b1;
          active_mode.rate_class <= 4'h1;
        end
        ACS_ADAPT_256:
        begin
          active_mode.adaptive <= 1'b1;
          active_mode.rate_class <= 4'h2;
        end
        ACS_ADAPT_64:
        begin
          active_mode.adaptive <= 1'b1;
          active_mode.rate_class <= 4'h4;
        end
        ACS_ADAPT_8:
        begin
          active_mode.adaptive <= 1'b1;
          active_mode.rate_class <= 4'h8;
        end
        ACS_CONT_1024:
        begin
          active_mode.continuous <= 1'b1;
          active_mode.rate_class <= 4'h1;
        end
        ACS_CONT_256:
        begin
          active_mode.continuous <= 1'b1;
          active_mode.rate_class <= 4'h2;
        end
        ACS_CONT_64:
        begin
          active_mode.continuous <= 1'b1;
          active_mode.rate_class <= 4'h4;
        end
        ACS_CONT_8:
        begin
          active_mode.continuous <= 1'b1;
          active_mode.rate_class <= 4'h8;
        end
        ACS_SINGLE:
        begin
          active_mode.single <= 1'b1;
        end
        ACS_SINGLE_8X:
        begin
          active_mode.single <= 1'b1;
          active_mode.avg8 <= 1'b1;
        end
        ACS_FAST:
        begin
          active_mode.fast <= 1'b1;
        end
        ACS_BURST:
        begin
          active_mode.burst <= 1'b1;
        end
        ACS_SLEEP:
        begin
          active_mode.sleep <= 1'b1;
        end
        default: active_mode.reserved <= 1'b1;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Dual-purpose pins
  assign fn[0] = active_control_copy_q[`ACS_PIN1_MSB:`ACS_PIN1_LSB];
  assign fn[1] = active_control_copy_q[`ACS_PIN2_MSB:`ACS_PIN2_LSB];

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      pin_m_q <= 2'h0;
      pin_s_q <= 2'h0;
    end
    else
    begin
      pin_m_q <= pin_in;
      pin_s_q <= pin_m_q;
    end
  end

  genvar p;
  generate
    for (p = 0; p < 2; p++)
    begin : g_pin
      always_ff @(posedge clk or negedge resetn)
      begin
        if (!resetn)
        begin
          gpi_level[p] <= 1'b0;
          pin_out[p] <= 1'b0;
          pin_oe[p] <= 1'b0;
        end
        else
        begin
          if (fn[p] == `ACS_PIN_GPI)
            gpi_level[p] <= pin_s_q[p];
          pin_out[p] <= gpo_level[p];
          pin_oe[p] <= fn[p] == `ACS_PIN_GPO;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      force_8sps <= 1'b0;
    else
      force_8sps <= (fn[0] == `ACS_PIN_RATE && pin_s_q[0]) ||
        (fn[1] == `ACS_PIN_RATE && pin_s_q[1]);
  end

  ////////////////////////////////////////////////////////////////////////
  // Channel enables
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      chan_active <= 4'h0;
      chan_count <= 3'h0;
      ptr_skip_enable <= 1'b0;
    end
    else
    begin
      chan_active <= ~active_control_copy_q[`ACS_OFF_MSB:`ACS_OFF_LSB];
      chan_count <= 3'(4 - $countones(
        active_control_copy_q[`ACS_OFF_MSB:`ACS_OFF_LSB]));
      ptr_skip_enable <= ~active_control_copy_q[`ACS_SKIP_BIT];
    end
  end

  // pin_refresh only refreshes results elsewhere; active copies untouched
  logic unused_pin_refresh;
  assign unused_pin_refresh = pin_refresh;
endmodule

// [test/acs_host_model.sv]
// Purpose: Host side register access
// Assumes: One request per call
// Notes: Read data taken one cycle after rd
`timescale 1ns/1ps
module acs_host_model
  import acs_pkg::*;
(
  input wire logic clk,
  output acs_req_s req,
  input wire logic [15:0] rdata,
  input wire logic rvalid
);
  initial req = '0;
  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    @(posedge clk);
    req <= '{1'b1, 1'b0, a, v};
    @(posedge clk);
    req <= '0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [15:0] v);
    @(posedge clk);
    req <= '{1'b0, 1'b1, a, 16'h0000};
    @(posedge clk);
    req <= '0;
    #1 v = rvalid ? rdata : 16'hdead;
  endtask
endmodule

// [test/acs_active_copy_monitor.sv]
// Purpose: Port checks for the active copies
// Assumes: Short settle count in simulation
// Notes: Bound to the design
`timescale 1ns/1ps
module acs_active_copy_monitor
  import acs_pkg::*;
#(
  parameter int SETTLE_CYC = 16
)
(
  input wire logic clk,
  input wire logic resetn,
  input wire acs_req_s req,
  input wire logic refresh,
  input wire logic pin_refresh,
  input wire logic [1:0] gpo_level,
  input wire logic [15:0] rdata,
  input wire logic rvalid,
  input wire logic copies_valid,
  input wire acs_mode_s active_mode,
  input wire logic [1:0] pin_out,
  input wire logic [1:0] pin_oe,
  input wire logic [3:0] chan_active,
  input wire logic [2:0] chan_count
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  a_read_answer: assert property (req.rd |=> rvalid)
    else $error("read not answered");
  a_no_stray: assert property (!req.rd |=> !rvalid)
    else $error("stray read answer");
  a_ctrl_low_zero: assert property
    (req.rd && req.addr == 8'h21 |=> rdata[3:0] == 4'h0)
    else $error("low control bits set");
  a_refresh_settle: assert property
    (refresh |=> !copies_valid [*8])
    else $error("copies valid too early");
  a_pin_keeps: assert property
    (pin_refresh && !refresh && copies_valid |=> copies_valid)
    else $error("pin refresh touched copies");
  a_count_match: assert property
    (chan_count == 3'($countones(chan_active)))
    else $error("channel count wrong");
  a_single_mode: assert property
    ($onehot0({active_mode.adaptive, active_mode.continuous,
      active_mode.fast, active_mode.burst, active_mode.sleep,
      active_mode.reserved}))
    else $error("several modes at once");
  a_gpo_follow: assert property
    (pin_oe[1] && $past(pin_oe[1]) |-> pin_out[1] == $past(gpo_level[1]))
    else $error("output pin level wrong");
  c_refresh: cover property (refresh ##1 !copies_valid);
  c_valid: cover property ($rose(copies_valid));
  c_drive: cover property (pin_oe[1]);
endmodule
bind acs_active_copy acs_active_copy_monitor #(.SETTLE_CYC(SETTLE_CYC)) mon_u
(
  .clk(clk), .resetn(resetn), .req(req), .refresh(refresh),
  .pin_refresh(pin_refresh), .gpo_level(gpo_level), .rdata(rdata),
  .rvalid(rvalid), .copies_valid(copies_valid), .active_mode(active_mode),
  .pin_out(pin_out), .pin_oe(pin_oe), .chan_active(chan_active),
  .chan_count(chan_count)
);

// [test/tb_active_config_shadow_regs.sv]
// Purpose: Self-checking bench for the active copies
// Assumes: Settle count cut to 16 cycles
// Notes: Host model issues register accesses
`timescale 1ns/1ps
module tb_active_config_shadow_regs
  import acs_pkg::*;
;
  logic clk = 0, resetn = 0, refresh = 0, prf = 0, cdone = 0;
  logic [1:0] pin_in = 2'h0, gpo = 2'h0, gpi, po, poe;
  acs_req_s req;
  acs_mode_s am;
  logic [15:0] rdata, d;
  logic rvalid, cv, f8, skp;
  logic [3:0] ca;
  logic [2:0] cc;
  int err_total = 0, compares = 0;
  always #2 clk = ~clk;
  acs_active_copy #(.SETTLE_CYC(16)) dut_u
  (
    .clk(clk), .resetn(resetn), .req(req), .refresh(refresh),
    .pin_refresh(prf), .cycle_done(cdone), .pin_in(pin_in),
    .gpo_level(gpo), .rdata(rdata), .rvalid(rvalid), .copies_valid(cv),
    .active_mode(am), .force_8sps(f8), .gpi_level(gpi), .pin_out(po),
    .pin_oe(poe), .chan_active(ca), .chan_count(cc),
    .ptr_skip_enable(skp)
  );
  acs_host_model host_u
  (
    .clk(clk), .req(req), .rdata(rdata), .rvalid(rvalid)
  );
  ////////////////////////////////////////////////////////////////////
  task automatic chk(string n, logic [15:0] e, logic [15:0] g);
    compares++;
    if (g !== e)
    begin
      $display("MISMATCH %s exp %h got %h", n, e, g);
      err_total++;
    end
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [15:0] e);
    host_u.rd(a, d);
    chk($sformatf("reg_%h", a), e, d);
  endtask
  task automatic pulse(input logic [2:0] m);
    @(posedge clk);
    {cdone, prf, refresh} <= m;
    @(posedge clk);
    {cdone, prf, refresh} <= 3'h0;
  endtask
  task automatic settle();
    int n;
    pulse(3'h4);
    for (n = 0; n < 100 && cv !== 1'b1; n++)
      @(posedge clk);
    chk("copies_valid", 16'h1, cv);
  endtask
  task automatic cfg(input logic [15:0] c);
    host_u.wr(8'h01, c);
    pulse(3'h1);
    settle();
  endtask
  function automatic logic flag(input logic [3:0] c);
    case (c)
      4'h0, 4'h1, 4'h2, 4'h3: return am.adaptive;
      4'h4, 4'h5, 4'h6, 4'h7: return am.continuous;
      4'h8: return am.single;
      4'h9: return am.avg8;
      4'ha: return am.fast;
      4'hb: return am.burst;
      4'hf: return am.sleep;
      default: return am.reserved;
    endcase
  endfunction
  ////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    rdchk(8'h21, 16'h0700);
    rdchk(8'h22, 16'h0000);
    rdchk(8'h40, 16'h0000);
    chk("skip", 16'h1, skp);
    chk("oe", 16'h0, poe);
    $display("t_reset done");
  endtask
  task automatic t_pending();
    host_u.wr(8'h01, 16'h4952);
    host_u.wr(8'h1d, 16'h9c63);
    host_u.wr(8'h21, 16'hffff);
    rdchk(8'h21, 16'h0700);
    rdchk(8'h22, 16'h0000);
    pulse(3'h1);
    rdchk(8'h21, 16'h0700);
    rdchk(8'h22, 16'h9c63);
    settle();
    rdchk(8'h21, 16'h4950);
    chk("chan_active", 16'ha, ca);
    chk("chan_count", 16'h2, cc);
    chk("skip", 16'h0, skp);
    chk("oe", 16'h2, poe);
    @(posedge clk);
    gpo <= 2'h3;
    pin_in <= 2'h1;
    repeat (4) @(posedge clk);
    #1 chk("pin_out", 16'h1, po[1]);
    chk("gpi", 16'h1, gpi[0]);
    host_u.wr(8'h01, 16'h0700);
    pulse(3'h2);
    rdchk(8'h21, 16'h4950);
    $display("t_pending done");
  endtask
  task automatic t_modes();
    logic [3:0] c;
    for (int i = 0; i < 16; i++)
    begin
      c = 4'(i);
      cfg({c, 12'h700});
      chk("mode", 16'h1, flag(c));
      if (i < 12 || i == 15)
        rdchk(8'h21, {c, 12'h700});
      if (i < 8)
        chk("rate", 16'h1 << i[1:0], am.rate_class);
    end
    repeat (4) @(posedge clk);
    #1 chk("force", 16'h1, f8);
    $display("t_modes done");
  endtask
  ////////////////////////////////////////////////////////////////////
  task automatic test_done();
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    t_reset();
    t_pending();
    t_modes();
    test_done();
  end
  initial
  begin
    repeat (20000) @(posedge clk);
    err_total++;
    test_done();
  end
endmodule
